//--- inc/bit_test_branch_pkg.sv
package bit_test_branch_pkg;
  // ===========================================
  // Widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned BITPOS_W = 5;
  localparam int unsigned CC_W = 3;
  localparam int unsigned DISP_HI = 12;
  localparam int unsigned DISP_LO = 2;
  localparam int unsigned DISP_W = DISP_HI - DISP_LO + 1;
  localparam int unsigned ALIGN_W = 2;
  // ===========================================
  // Condition code and reset values
  localparam logic [2:0] CC_CLEAR = 3'h0;
  localparam logic [2:0] CC_SET = 3'h2;
  localparam logic [2:0] CC_RESET = 3'h0;
  localparam logic [31:0] IP_RESET = 32'h0000_0000;
  // ===========================================
  // Operation select
  typedef enum logic {
    OP_BRANCH_IF_CLEAR,
    OP_BRANCH_IF_SET
  } bit_test_op_t;
endpackage

//--- hw/bit_select.sv
`timescale 1ns/1ps
module bit_select
  import bit_test_branch_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W
) (
  input wire logic [WIDTH-1:0] i_word,
  input wire logic [WORD_W-1:0] i_pos,
  output logic o_bit
);
  // Truncating the position is a modulo only when the width is a power of two
  if (WIDTH != (1 << BITPOS_W)) begin : g_chk_width
    $error("bit_select: WIDTH must equal 2**BITPOS_W");
  end

  // Only the low bits of the position count: modulo the word width
  always_comb begin
    o_bit = i_word[i_pos[BITPOS_W-1:0]];
  end
endmodule

//--- hw/bit_test_branch_unit.sv
`timescale 1ns/1ps
module bit_test_branch_unit
  import bit_test_branch_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic i_op_set,
  input wire logic [WORD_W-1:0] i_bitpos,
  input wire logic [WORD_W-1:0] i_src,
  input wire logic [WORD_W-1:0] i_disp,
  input wire logic [WORD_W-1:0] i_ip,
  input wire logic [WORD_W-1:0] i_next_ip,
  output logic o_done,
  output logic o_taken,
  output logic [CC_W-1:0] o_arithmetic_controls_cc,
  output logic [WORD_W-1:0] o_ip
);
  // ===========================================
  // Elaboration checks
  // The selector truncates the position, which is a modulo only for a power of two
  if (WORD_W != (1 << BITPOS_W)) begin : g_chk_word
    $error("bit_test_branch_unit: WORD_W must equal 2**BITPOS_W");
  end

  // The field is placed where it stands, so its low end must meet the alignment
  if (DISP_LO != ALIGN_W) begin : g_chk_align
    $error("bit_test_branch_unit: DISP_LO must equal ALIGN_W");
  end

  // At least one sign bit must remain above the field
  if (DISP_HI <= DISP_LO || DISP_HI >= WORD_W - 1) begin : g_chk_disp
    $error("bit_test_branch_unit: displacement field does not fit the word");
  end

  if (CC_W != $bits(CC_CLEAR) || CC_CLEAR == CC_SET) begin : g_chk_cc
    $error("bit_test_branch_unit: condition code constants do not fit CC_W");
  end

  // A reset pointer off the word grid could never be reached by a branch
  if (IP_RESET[ALIGN_W-1:0] != '0) begin : g_chk_ip_reset
    $error("bit_test_branch_unit: IP_RESET must be word aligned");
  end

  // ===========================================
  // Operation decode
  bit_test_op_t op;

  always_comb begin
    case (i_op_set)
      1'b1: begin
        op = OP_BRANCH_IF_SET;
      end
      default: begin
        op = OP_BRANCH_IF_CLEAR;
      end
    endcase
  end

  // ===========================================
  // Bit test
  // Register and literal positions arrive alike; only the low bits select
  logic tested_bit;

  bit_select #(.WIDTH(WORD_W)) u_sel (
    .i_word(i_src),
    .i_pos(i_bitpos),
    .o_bit(tested_bit)
  );

  // ===========================================
  // Displacement and target
  // Only field bits reach the adder; the rest of i_disp is ignored, which bounds the reach
  localparam int unsigned FILL_W = WORD_W - DISP_HI - 1;
  logic [FILL_W-1:0] sign_fill;
  logic [WORD_W-1:0] disp_ext;
  logic [WORD_W-ALIGN_W-1:0] ip_word;
  logic [WORD_W-ALIGN_W-1:0] disp_word;
  logic [WORD_W-ALIGN_W-1:0] sum_word;
  logic [WORD_W-1:0] target;

  for (genvar gi = 0; gi < FILL_W; gi++) begin : g_sign_fill
    assign sign_fill[gi] = i_disp[DISP_HI];
  end

  always_comb begin
    disp_ext = {sign_fill, i_disp[DISP_HI:DISP_LO], {ALIGN_W{1'b0}}};
    ip_word = i_ip[WORD_W-1:ALIGN_W];
    disp_word = disp_ext[WORD_W-1:ALIGN_W];
    // Word arithmetic: a carry out of the top drops, so the pointer wraps
    sum_word = ip_word + disp_word;
    target = {sum_word, {ALIGN_W{1'b0}}};
  end

  // ===========================================
  // Branch decision
  logic hit;

  always_comb begin
    hit = 1'b0;
    case (op)
      OP_BRANCH_IF_CLEAR: begin
        hit = ~tested_bit;
      end
      OP_BRANCH_IF_SET: begin
        hit = tested_bit;
      end
      // An operation outside the two never branches
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ===========================================
  // Completion strobe
  // Stands one cycle after each request; an idle cycle clears it
  logic done_d;
  logic done_q;

  always_comb begin
    done_d = i_valid;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // ===========================================
  // Taken strobe
  // Rises with the completion strobe only when the branch goes
  logic taken_d;
  logic taken_q;

  always_comb begin
    taken_d = i_valid & hit;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= taken_d;
    end
  end

  // ===========================================
  // Condition code
  // Both instructions leave 010 when the bit is one and 000 when it is zero
  logic [CC_W-1:0] cc_d;
  logic [CC_W-1:0] cc_q;

  always_comb begin
    // Idle cycles keep the last code for a later conditional branch
    cc_d = cc_q;
    if (i_valid) begin
      case (op)
        OP_BRANCH_IF_CLEAR: begin
          cc_d = hit ? CC_CLEAR : CC_SET;
        end
        OP_BRANCH_IF_SET: begin
          cc_d = hit ? CC_SET : CC_CLEAR;
        end
        default: begin
          cc_d = cc_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cc_q <= CC_RESET;
    end else begin
      cc_q <= cc_d;
    end
  end

  // ===========================================
  // Instruction pointer
  // Written on the same edge as the code, so the next instruction sees both
  logic [WORD_W-1:0] ip_d;
  logic [WORD_W-1:0] ip_q;

  always_comb begin
    ip_d = ip_q;
    if (i_valid) begin
      if (hit) begin
        ip_d = target;
      end else begin
        // Fall-through address is supplied by the fetch stage
        ip_d = i_next_ip;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ip_q <= IP_RESET;
    end else begin
      ip_q <= ip_d;
    end
  end

  // ===========================================
  // Outputs
  // Straight from the registers, with no logic behind them
  assign o_done = done_q;
  assign o_taken = taken_q;
  assign o_arithmetic_controls_cc = cc_q;
  assign o_ip = ip_q;

endmodule

//--- sim/btb_sva.sv
`timescale 1ns/1ps
module btb_sva
  import bit_test_branch_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic i_op_set,
  input wire logic [31:0] i_bitpos,
  input wire logic [31:0] i_src,
  input wire logic [31:0] i_ip,
  input wire logic o_done,
  input wire logic o_taken,
  input wire logic [2:0] o_arithmetic_controls_cc,
  input wire logic [31:0] o_ip
);
  // ==========
  // Checks
  wire logic b = i_src[i_bitpos[4:0]];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_cc; i_valid |=> o_arithmetic_controls_cc == {1'h0, $past(b), 1'h0}; endproperty
  a_cc: assert property (p_cc) else $error("cc");
  property p_tk; i_valid |=> o_taken == ($past(b) == $past(i_op_set)); endproperty
  a_tk: assert property (p_tk) else $error("taken");
  property p_al; o_taken |-> o_ip[1:0] == 2'h0 && o_done; endproperty
  a_al: assert property (p_al) else $error("align");
  property p_rc; i_valid ##1 o_taken |->
    o_ip - {$past(i_ip[31:2]), 2'h0} + 32'h1000 < 32'h2000; endproperty
  a_rc: assert property (p_rc) else $error("reach");
  property p_hd; !o_done |-> $stable(o_arithmetic_controls_cc) && $stable(o_ip); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_dn; i_valid |=> o_done; endproperty
  a_dn: assert property (p_dn) else $error("done");
endmodule
bind bit_test_branch_unit btb_sva chk(.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_valid(i_valid), .i_op_set(i_op_set), .i_bitpos(i_bitpos), .i_src(i_src), .i_ip(i_ip),
  .o_done(o_done), .o_taken(o_taken), .o_arithmetic_controls_cc(o_arithmetic_controls_cc),
  .o_ip(o_ip));

//--- sim/bit_test_branch_unit_test.sv
`timescale 1ns/1ps
module bit_test_branch_unit_test;
  logic i_ref_clk = 0, i_rst_n = 0, i_valid = 0, i_op_set = 0, o_done, o_taken, t;
  logic [31:0] i_bitpos = 0, i_src = 0, i_disp = 0, i_ip = 0, i_next_ip = 0, o_ip;
  logic [31:0] r = 32'h0000_004a;
  logic [2:0] o_arithmetic_controls_cc;
  int n_errors = 0, n_compared = 0, ed = 0, et = 0, ec = 0, ei = 0;
  bit_test_branch_unit uut(.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_op_set(i_op_set), .i_bitpos(i_bitpos), .i_src(i_src), .i_disp(i_disp), .i_ip(i_ip),
    .i_next_ip(i_next_ip), .o_done(o_done), .o_taken(o_taken),
    .o_arithmetic_controls_cc(o_arithmetic_controls_cc), .o_ip(o_ip));
  always #2.5 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] nx();
    r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r;
  endfunction
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // Random back-to-back and idle cycles; idle cycles must leave results held
  initial begin
    repeat (5) @(negedge i_ref_clk);
    i_rst_n = 1;
    repeat (500) begin
      @(negedge i_ref_clk);
      chk("done", ed, o_done);
      chk("taken", et, o_taken);
      chk("cc", ec, o_arithmetic_controls_cc);
      chk("ip", ei, o_ip);
      i_src = nx();
      i_bitpos = nx();
      i_disp = nx();
      i_ip = nx();
      i_next_ip = nx();
      r = nx();
      i_valid = r[0];
      i_op_set = r[1];
      t = i_src[i_bitpos % 32];
      ed = i_valid;
      et = i_valid && t == i_op_set;
      if (i_valid) ec = t ? 2 : 0;
      if (i_valid) ei = et ? (i_ip & ~3) + {{19{i_disp[12]}}, i_disp[12:2], 2'h0} : i_next_ip;
    end
    $display("random run done");
    test_done;
  end
  initial begin
    #4000;
    n_errors++;
    test_done;
  end
endmodule
